/* cse_pkg.sv */
// Constants and types for the compare-and-skip execution block
`default_nettype none
package cse_pkg;
	// Opcode, upper seven bits of the instruction word
	localparam logic [6:0] CSE_OPC_LESS = 7'h30;
	localparam logic [6:0] CSE_OPC_EQUAL = 7'h31;
	localparam logic [6:0] CSE_OPC_GREATER = 7'h32;
	localparam int CSE_OPC_MSB = 15;
	localparam int CSE_OPC_LSB = 9;
	// Bank-select operand bit and file address field
	localparam int CSE_ABIT_POS = 8;
	localparam int CSE_FILE_MSB = 7;
	// Fixed access bank: low half maps to bank 0, high half to the top bank
	localparam logic [7:0] CSE_ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] CSE_ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] CSE_ACCESS_HIGH_BANK = 4'hf;
	// Quarter phases of one instruction cycle
	localparam logic [1:0] CSE_PH_Q1 = 2'h0;
	localparam logic [1:0] CSE_PH_Q2 = 2'h1;
	localparam logic [1:0] CSE_PH_Q3 = 2'h2;
	localparam logic [1:0] CSE_PH_Q4 = 2'h3;
	// Skip lengths in program words
	localparam logic [1:0] CSE_SKIP_ONE = 2'h1;
	localparam logic [1:0] CSE_SKIP_TWO = 2'h2;
	// Reset values
	localparam logic [11:0] CSE_ADDR_RESET = 12'h000;
	localparam logic [7:0] CSE_BYTE_RESET = 8'h00;
	localparam logic [1:0] CSE_WORDS_RESET = 2'h0;

	typedef enum logic [1:0] {CSE_OP_EQUAL, CSE_OP_GREATER, CSE_OP_LESS} cse_op_t;
	typedef enum logic [1:0] {CSE_IDLE, CSE_COMPARE, CSE_SKIP} cse_state_t;
endpackage
`default_nettype wire

/* cse_exec.sv */
// Compare-and-skip instruction execution with quarter-phase sequencing
// Operation
// RULE1: Decode equal compare; skip when byte equals working
// RULE2: Decode greater compare; low byte is file address
// RULE3: Greater skips only when byte strictly larger
// RULE4: Decode less compare; low byte is file address
// RULE5: Less skips only when byte strictly smaller
// RULE6: Unsigned subtract, result and flags never written
// RULE7: Skip replaces next instruction with idle instruction
// RULE8: Two-word skipped instruction costs three cycles total
// RULE9: Operand bit 0 selects fixed access bank
// RULE10: Operand bit 1 uses bank select register
// RULE11: Decode Q1, read Q2, compare Q3, no write
// RULE12: One word; skip advances past one more instruction
`default_nettype none
module cse_exec
	import cse_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [7:0] working_register,
	input wire logic [3:0] bank_select_register,
	input wire logic [7:0] file_data,
	input wire logic next_is_two_word,
	output logic [1:0] quarter_phase,
	output logic compare_busy,
	output logic file_read,
	output logic [11:0] file_addr,
	output logic skip_active,
	output logic pc_skip_valid,
	output logic [1:0] pc_skip_words
);

	cse_state_t state;
	cse_state_t next_state;
	cse_op_t op;
	logic abit;
	logic [7:0] file_field;
	logic [7:0] operand;
	logic skip_cond;
	logic [1:0] skip_left;

	// Decode of the word presented in Q1
	wire [6:0] opc = instr_word[CSE_OPC_MSB:CSE_OPC_LSB];
	wire is_equal = (opc == CSE_OPC_EQUAL); // RULE1
	wire is_greater = (opc == CSE_OPC_GREATER); // RULE2
	wire is_less = (opc == CSE_OPC_LESS); // RULE4
	wire is_cmp = is_equal | is_greater | is_less;
	wire cse_op_t dec_op = is_equal ? CSE_OP_EQUAL : (is_greater ? CSE_OP_GREATER : CSE_OP_LESS);
	wire dec_abit = instr_word[CSE_ABIT_POS];
	wire [7:0] dec_file = instr_word[CSE_FILE_MSB:0]; // RULE2 RULE4

	// Sequencing events
	wire start = (state == CSE_IDLE) && (quarter_phase == CSE_PH_Q1) && instr_valid && is_cmp; // RULE11
	wire read_end = (state == CSE_COMPARE) && (quarter_phase == CSE_PH_Q2);
	wire cmp_edge = (state == CSE_COMPARE) && (quarter_phase == CSE_PH_Q3);
	wire compare_end = (state == CSE_COMPARE) && (quarter_phase == CSE_PH_Q4);
	wire skip_end = (state == CSE_SKIP) && (quarter_phase == CSE_PH_Q4) && (skip_left == CSE_SKIP_ONE);
	wire skip_tick = (state == CSE_SKIP) && (quarter_phase == CSE_PH_Q4);

	// Address forming; the access bank splits its byte range over two banks
	wire [3:0] access_bank = (file_field >= CSE_ACCESS_SPLIT) ? CSE_ACCESS_HIGH_BANK : CSE_ACCESS_LOW_BANK; // RULE9
	wire [3:0] dec_access_bank = (dec_file >= CSE_ACCESS_SPLIT) ? CSE_ACCESS_HIGH_BANK : CSE_ACCESS_LOW_BANK; // RULE9
	wire [3:0] dec_bank = dec_abit ? bank_select_register : dec_access_bank; // RULE10
	wire [11:0] next_file_addr = {dec_bank, dec_file};

	// Borrow of the unsigned subtraction gives less, zero gives equal
	wire [8:0] diff = {1'b0, operand} - {1'b0, working_register}; // RULE6
	wire cmp_equal = (diff == 9'h000);
	wire cmp_less = diff[8]; // RULE5
	wire cmp_greater = !cmp_less && !cmp_equal; // RULE3
	wire next_skip_cond = (op == CSE_OP_EQUAL) ? cmp_equal : ((op == CSE_OP_GREATER) ? cmp_greater : cmp_less);
	wire [1:0] next_skip_words = next_is_two_word ? CSE_SKIP_TWO : CSE_SKIP_ONE; // RULE8 RULE12

	always_comb
	begin
		next_state = state;
		case (state)
			CSE_IDLE:
			begin
				if (start)
					next_state = CSE_COMPARE;
			end
			CSE_COMPARE:
			begin
				if (compare_end)
					next_state = skip_cond ? CSE_SKIP : CSE_IDLE; // RULE7
			end
			CSE_SKIP:
			begin
				if (skip_end)
					next_state = CSE_IDLE;
			end
			default:
			begin
				next_state = CSE_IDLE;
			end
		endcase
	end

	// Free-running quarter phase counter
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			quarter_phase <= CSE_PH_Q1;
		else
			quarter_phase <= quarter_phase + 2'h1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state <= CSE_IDLE;
		else
			state <= next_state;
	end

	// Operand capture at the end of Q1
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			op <= CSE_OP_EQUAL;
			abit <= 1'b0;
			file_field <= CSE_BYTE_RESET;
		end
		else if (start)
		begin
			op <= dec_op;
			abit <= dec_abit;
			file_field <= dec_file;
		end
	end

	// File read strobe covers Q2 only
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			file_read <= 1'b0;
		else
			file_read <= start; // RULE11
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			file_addr <= CSE_ADDR_RESET;
		else if (start)
			file_addr <= next_file_addr; // RULE9 RULE10
	end

	// Data is latched as Q2 ends so the compare sees a stable byte
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			operand <= CSE_BYTE_RESET;
		else if (read_end)
			operand <= file_data;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			skip_cond <= 1'b0;
		else if (cmp_edge)
			skip_cond <= next_skip_cond; // RULE1 RULE3 RULE5
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			compare_busy <= 1'b0;
		else if (start)
			compare_busy <= 1'b1;
		else if (compare_end)
			compare_busy <= 1'b0;
	end

	// Each skipped word costs one full idle instruction cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			skip_left <= CSE_WORDS_RESET;
		else if (compare_end && skip_cond)
			skip_left <= next_skip_words; // RULE8
		else if (skip_tick)
			skip_left <= skip_left - 2'h1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			skip_active <= 1'b0;
		else if (compare_end && skip_cond)
			skip_active <= 1'b1; // RULE7
		else if (skip_end)
			skip_active <= 1'b0;
	end

	// The fetch unit adds these words on top of its normal step
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pc_skip_valid <= 1'b0;
			pc_skip_words <= CSE_WORDS_RESET;
		end
		else
		begin
			pc_skip_valid <= compare_end && skip_cond; // RULE12
			if (compare_end && skip_cond)
				pc_skip_words <= next_skip_words;
		end
	end

	decode_equal_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
		start && is_equal |=> (state == CSE_COMPARE) && (op == CSE_OP_EQUAL))
		else $error("equal compare not decoded");

	decode_greater_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
		start && is_greater |=> (op == CSE_OP_GREATER) && (file_addr[7:0] == $past(instr_word[7:0])))
		else $error("greater compare not decoded");

	decode_less_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
		start && is_less |=> (op == CSE_OP_LESS) && file_read && (file_addr[7:0] == $past(instr_word[7:0])))
		else $error("less compare not decoded");

	skip_equal_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
		cmp_edge && (op == CSE_OP_EQUAL) |=> skip_cond == $past(operand == working_register))
		else $error("equal skip condition wrong");

	skip_greater_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
		cmp_edge && (op == CSE_OP_GREATER) |=> skip_cond == $past(operand > working_register))
		else $error("greater skip condition wrong");

	skip_less_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
		cmp_edge && (op == CSE_OP_LESS) |=> skip_cond == $past(operand < working_register))
		else $error("less skip condition wrong");

	operand_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
		compare_busy && !read_end |=> $stable(operand))
		else $error("operand changed during compare");

	skip_one_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
		pc_skip_valid && (pc_skip_words == CSE_SKIP_ONE) |-> skip_active [*4] ##1 !skip_active)
		else $error("single skip length wrong");

	skip_two_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE8
		pc_skip_valid && (pc_skip_words == CSE_SKIP_TWO) |-> skip_active [*8] ##1 !skip_active)
		else $error("double skip length wrong");

	bank_access_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE9
		file_read && !abit |-> file_addr[11:8] == access_bank)
		else $error("access bank address wrong");

	bank_select_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
		start && dec_abit |=> file_addr[11:8] == $past(bank_select_register))
		else $error("bank select address wrong");

	read_phase_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE11
		start |=> file_read && (quarter_phase == CSE_PH_Q2) ##1 !file_read ##2 !compare_busy)
		else $error("compare phase order wrong");

	pc_step_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
		$rose(skip_active) |-> pc_skip_valid && (pc_skip_words != CSE_WORDS_RESET))
		else $error("skip step not reported");

	busy_length_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE11
		start |=> compare_busy [*3] ##1 !compare_busy)
		else $error("compare cycle length wrong");

	busy_refuse_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE11
		compare_busy || skip_active |=> !file_read)
		else $error("take while busy");

	skip_quiet_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
		skip_active |-> !file_read && !compare_busy && (state == CSE_SKIP))
		else $error("activity during skip");

	noskip_end_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
		compare_end && !skip_cond |=> !pc_skip_valid && !skip_active && (state == CSE_IDLE))
		else $error("skip without condition");

	skip_words_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
		compare_end && skip_cond |=> pc_skip_valid
			&& (pc_skip_words == ($past(next_is_two_word) ? CSE_SKIP_TWO : CSE_SKIP_ONE)))
		else $error("skip word count wrong");

	equal_skip_c: cover property (@(posedge clk) disable iff (!reset_n)
		compare_end && skip_cond && (op == CSE_OP_EQUAL));
	greater_two_c: cover property (@(posedge clk) disable iff (!reset_n)
		pc_skip_valid && (pc_skip_words == CSE_SKIP_TWO) && (op == CSE_OP_GREATER));
	less_noskip_c: cover property (@(posedge clk) disable iff (!reset_n)
		compare_end && !skip_cond && (op == CSE_OP_LESS));
	bank_select_c: cover property (@(posedge clk) disable iff (!reset_n)
		file_read && abit);
	less_two_c: cover property (@(posedge clk) disable iff (!reset_n)
		skip_active && (skip_left == CSE_SKIP_TWO) && (op == CSE_OP_LESS));

endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench for the compare-and-skip execution block
`default_nettype none
module tb_top
	import cse_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic instr_valid = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	logic [7:0] working_register = 8'h00;
	logic [3:0] bank_select_register = 4'h0;
	logic [7:0] file_data = 8'h00;
	logic next_is_two_word = 1'b0;
	logic [1:0] quarter_phase;
	logic compare_busy;
	logic file_read;
	logic [11:0] file_addr;
	logic skip_active;
	logic pc_skip_valid;
	logic [1:0] pc_skip_words;
	int error_cnt = 0;
	int checks_done = 0;
	int exp_q[$];
	logic [7:0] edge_vals [6] = '{8'h00, 8'hff, 8'h7f, 8'h80, 8'h01, 8'hfe};

	cse_exec DUT (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
		.working_register(working_register), .bank_select_register(bank_select_register),
		.file_data(file_data), .next_is_two_word(next_is_two_word), .quarter_phase(quarter_phase),
		.compare_busy(compare_busy), .file_read(file_read), .file_addr(file_addr), .skip_active(skip_active),
		.pc_skip_valid(pc_skip_valid), .pc_skip_words(pc_skip_words));

	always #10 clk = ~clk;

	task automatic chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	// Check before waiting so that a take right after a plain compare stays back to back
	task automatic wait_idle();
		int n;
		n = 0;
		while (!(quarter_phase === CSE_PH_Q1 && compare_busy === 1'b0 && skip_active === 1'b0) && n < 40)
		begin
			tick();
			n++;
		end
		chk(n < 40, "block never idle");
	endtask

	task automatic run_op(input int op, input logic abit, input logic [7:0] f, input logic [7:0] fd,
		input logic [7:0] w, input logic [3:0] bk, input logic two);
		logic [6:0] opc;
		logic [11:0] ea;
		logic sk;
		int n;
		int fi;
		int wi;
		opc = (op == 0) ? CSE_OPC_EQUAL : (op == 1) ? CSE_OPC_GREATER : CSE_OPC_LESS;
		fi = fd;
		wi = w;
		sk = (op == 0) ? (fi == wi) : (op == 1) ? (fi > wi) : (fi < wi);
		exp_q.push_back(sk ? (two ? 8 : 4) : 0);
		ea = abit ? {bk, f} : {((f >= 8'h80) ? 4'hf : 4'h0), f};
		wait_idle();
		instr_word = {opc, abit, f};
		instr_valid = 1'b1;
		bank_select_register = bk;
		file_data = fd;
		working_register = w;
		next_is_two_word = two;
		tick();
		// Held during the skip too: a take there would be a fault
		instr_valid = sk;
		bank_select_register = 4'($urandom);
		chk(file_read === 1'b1 && compare_busy === 1'b1, "read not in second quarter");
		chk(file_addr === ea, "file address");
		tick();
		file_data = ~fd;
		chk(file_read === 1'b0 && compare_busy === 1'b1, "read pulse length");
		tick();
		working_register = ~w;
		tick();
		chk(compare_busy === 1'b0 && pc_skip_valid === sk && skip_active === sk, "skip decision");
		n = 0;
		if (sk)
		begin
			// Word count is already taken; a late sample would see the flip
			next_is_two_word = ~two;
			chk(pc_skip_words === (two ? CSE_SKIP_TWO : CSE_SKIP_ONE), "skip words");
			while (skip_active === 1'b1 && n < 12)
			begin
				tick();
				n++;
				// Dropped one edge early so a following take does not reassign it
				if (n == (two ? 7 : 3))
					instr_valid = 1'b0;
				chk(pc_skip_valid === 1'b0 && file_read === 1'b0, "skip pulse or read in skip");
			end
		end
		chk(n == exp_q.pop_front() && compare_busy === 1'b0, "skip length");
	endtask

	task automatic do_reset();
		reset_n = 1'b0;
		#1;
		chk({quarter_phase, compare_busy, file_read, file_addr, skip_active, pc_skip_valid, pc_skip_words} === 20'h0,
			"outputs in reset");
		repeat (6) @(posedge clk);
		#1;
		reset_n = 1'b1;
		tick();
		chk(quarter_phase === CSE_PH_Q2, "phase after release");
	endtask

	initial
	begin
		#100000;
		error_cnt++;
		close_out();
	end

	initial
	begin
		void'($urandom(32'h334e));
		repeat (6) @(posedge clk);
		#1;
		reset_n = 1'b1;
		tick();
		chk(quarter_phase === CSE_PH_Q2, "phase after release");
		for (int op = 0; op < 3; op++)
			for (int i = 0; i < 6; i++)
				for (int j = 0; j < 6; j += 2)
					run_op(op, 1'(i), 8'(16 * i + j), edge_vals[i], edge_vals[j ^ (i & 1)], 4'(i + j), 1'(j >> 1));
		$display("test boundary compares done");
		foreach (edge_vals[k])
		begin
			wait_idle();
			instr_word = {7'(k == 0 ? 7'h33 : 7'h30 + 7'(k) * 7'h10), 9'h010};
			instr_valid = 1'b1;
			tick();
			tick();
			instr_valid = 1'b0;
			chk(compare_busy === 1'b0 && file_read === 1'b0, "foreign opcode taken");
		end
		wait_idle();
		tick();
		instr_word = {CSE_OPC_EQUAL, 9'h000};
		instr_valid = 1'b1;
		tick();
		instr_valid = 1'b0;
		tick();
		chk(compare_busy === 1'b0, "take outside first quarter");
		$display("test refusals done");
		for (int r = 0; r < 40; r++)
			run_op($urandom % 3, 1'($urandom), 8'($urandom), ($urandom % 3 == 0) ? 8'h5a : 8'($urandom),
				($urandom % 2 == 0) ? 8'h5a : 8'($urandom), 4'($urandom), 1'($urandom));
		$display("test random compares done");
		do_reset();
		run_op(0, 1'b1, 8'h33, 8'h44, 8'h44, 4'h9, 1'b1);
		$display("test reset and rerun done");
		close_out();
	end
endmodule
`default_nettype wire
